/* File: dv/shexp_checker.sv */
// Port checker for the shutter exposure selector
`timescale 1ns/1ps
module shexp_checker (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Address
  input wire logic [3:0] wb_sel_i, // Selects
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic wb_err_o, // Error
  input wire logic hsync_i, // Line pulse
  input wire logic vsync_i, // Frame pulse
  input wire logic trig_n_i, // Trigger
  input wire logic expose_o, // Exposing
  input wire logic expose_done_o // End pulse
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_err_pulse; wb_err_o |=> !wb_err_o; endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("err too long");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_answer; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o;
  endproperty
  a_answer: assert property (p_answer) else $error("no bus answer");
  property p_excl; !(wb_ack_o && wb_err_o); endproperty
  a_excl: assert property (p_excl) else $error("ack with err");
  property p_done_end; expose_done_o |-> !expose_o && $past(expose_o); endproperty
  a_done_end: assert property (p_done_end) else $error("done off exposure end");
  property p_fall_done; $fell(expose_o) |-> expose_done_o ##1 !expose_done_o; endproperty
  a_fall_done: assert property (p_fall_done) else $error("end without done");
  property p_rst_quiet; disable iff (1'b0) rst_i |=> !expose_o && !wb_ack_o && !wb_err_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs live in reset");
  c_done: cover property (expose_done_o);
  c_err: cover property (wb_err_o);
  c_wr: cover property (wb_ack_o && $past(wb_we_i));
endmodule : shexp_checker

bind shexp_top shexp_checker shexp_checker_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .hsync_i(hsync_i), .vsync_i(vsync_i), .trig_n_i(trig_n_i),
  .expose_o(expose_o), .expose_done_o(expose_done_o));

/* File: dv/shexp_sync_src.sv */
// Line, frame and trigger source facing the selector
`timescale 1ns/1ps
module shexp_sync_src #(
  parameter int HP = 4,
  parameter int LPF = 10
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset, active high
  input wire logic trig_go_i, // Start a trigger pulse
  input wire logic [15:0] trig_len_i, // Low time in cycles
  output logic hsync_o, // Line pulse
  output logic vsync_o, // Frame pulse
  output logic trig_n_o // Trigger, active low
);
  int cnt;
  int tcnt;
  assign hsync_o = (cnt % HP == 0);
  assign vsync_o = (cnt == 0);
  assign trig_n_o = (tcnt == 0);
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 0;
      tcnt <= 0;
    end else begin
      cnt <= (cnt == HP * LPF - 1) ? 0 : cnt + 1;
      if (trig_go_i) begin
        tcnt <= int'(trig_len_i);
      end else if (tcnt > 0) begin
        tcnt <= tcnt - 1;
      end
    end
  end
endmodule : shexp_sync_src

/* File: dv/tb.sv */
// Self-checking bench for the shutter exposure selector
`timescale 1ns/1ps
module tb;
  import shexp_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, go, hs, vs, tn, ack, err, expo, done;
  logic [7:0] adr;
  logic [31:0] wd, rdat;
  logic [15:0] tlen;
  int fails, n_compared, len;
  int hs_tab[10] = '{0, 1, 2, 4, 8, 17, 35, 72, 144, 298};
  shexp_top shexp_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .hsync_i(hs), .vsync_i(vs), .trig_n_i(tn),
    .expose_o(expo), .expose_done_o(done));
  shexp_sync_src shexp_sync_src_i (.clk_i(clk_i), .rst_i(rst_i), .trig_go_i(go),
    .trig_len_i(tlen), .hsync_o(hs), .vsync_o(vs), .trig_n_o(tn));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rng(input int got, input int lo, input int hi, input string m);
    n_compared++;
    if (got < lo || got > hi) begin
      fails++;
      $display("BAD %0t %s length %0d", $time, m, got);
    end
  endtask : rng
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    q = rdat;
    e = err;
    if (n >= 50) fails++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bus(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string m);
    logic [31:0] q;
    logic e;
    bus(1'b0, a, 32'h0, q, e);
    chk(q, x, m);
  endtask : rd
  // Waits for idle, optionally triggers, then counts exposure cycles
  task automatic expo_len(input int tl);
    int n;
    n = 0;
    len = 0;
    while (expo === 1'b1 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    if (tl > 0) begin
      tlen <= 16'(tl);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
    end
    while (expo !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    while (expo === 1'b1 && len < 2000) begin
      @(posedge clk_i);
      len++;
    end
  endtask : expo_len
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_defaults;
    for (int p = 1; p <= 9; p++) begin
      wr(ADR_SWITCH, 32'(p));
      rd(ADR_ACTIVE, 32'(hs_tab[p]), "hs default");
      wr(ADR_CTRL, 32'h2);
      rd(ADR_ACTIVE, 32'(p + 1), "ls default");
      wr(ADR_CTRL, 32'h0);
    end
    wr(ADR_SWITCH, 32'hA);
    rd(ADR_SWITCH, 32'h9, "switch keep");
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_table;
    logic [31:0] q;
    logic e;
    wr(ADR_TBL_IDX, 32'h3);
    wr(ADR_TBL_DAT, 32'h55);
    wr(ADR_SWITCH, 32'h3);
    rd(ADR_ACTIVE, 32'h55, "edited entry");
    wr(ADR_MODE, 32'h1);
    wr(ADR_CTRL, 32'h18);
    rd(ADR_ACTIVE, 32'h4, "other page");
    rd(ADR_MODE, 32'h11, "mode saved");
    wr(ADR_MODE, 32'h0);
    wr(ADR_CTRL, 32'h18);
    rd(ADR_ACTIVE, 32'h55, "page back");
    wr(ADR_TBL_IDX, 32'h0);
    wr(ADR_TBL_DAT, 32'h7);
    wr(ADR_SWITCH, 32'h0);
    expo_len(0);
    chk(32'(len), 32'd40, "full frame");
    bus(1'b0, 8'h40, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped");
    $display("test table done");
  endtask : t_table
  task automatic t_direct;
    wr(ADR_SWITCH, 32'h2);
    wr(ADR_DIRECT, 32'h7);
    rd(ADR_ACTIVE, 32'h7, "direct");
    wr(ADR_DIRECT, 32'h23D);
    rd(ADR_ACTIVE, 32'h2, "over max");
    rd(ADR_DIRECT, 32'h123D, "range flag");
    wr(ADR_DIRECT, 32'h0);
    rd(ADR_ACTIVE, 32'h2, "cancel");
    $display("test direct done");
  endtask : t_direct
  task automatic t_expo;
    wr(ADR_CTRL, 32'h0);
    expo_len(0);
    rng(len, 4, 9, "hs lines");
    wr(ADR_CTRL, 32'h2);
    wr(ADR_SWITCH, 32'h1);
    expo_len(0);
    rng(len, 79, 81, "ls frames");
    wr(ADR_CTRL, 32'h5);
    wr(ADR_SWITCH, 32'h9);
    expo_len(13);
    chk(32'(len), 32'd13, "pulse width");
    wr(ADR_CTRL, 32'h1);
    expo_len(3);
    rng(len, 1185, 1194, "preset nine");
    $display("test exposure done");
  endtask : t_expo
  task automatic final_report;
    $display("compared %0d, bad %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  initial begin
    {cyc, stb, we, go, adr, wd, tlen} = '0;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_defaults();
    t_table();
    t_direct();
    t_expo();
    final_report();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    fails++;
    final_report();
  end
endmodule : tb

/* File: inc/shexp_pkg.sv */
// Package of constants and types for the shutter exposure selector
package shexp_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_SWITCH = 8'h04;
  localparam logic [7:0] ADR_MODE = 8'h08;
  localparam logic [7:0] ADR_DIRECT = 8'h0C;
  localparam logic [7:0] ADR_TBL_IDX = 8'h10;
  localparam logic [7:0] ADR_TBL_DAT = 8'h14;
  localparam logic [7:0] ADR_STATUS = 8'h18;
  localparam logic [7:0] ADR_COUNT = 8'h1C;
  localparam logic [7:0] ADR_ACTIVE = 8'h20;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int CTRL_ASYNC_BIT = 0;
  localparam int CTRL_LOWSPD_BIT = 1;
  localparam int CTRL_PWE_BIT = 2;
  localparam int CTRL_SAVE_BIT = 3;
  localparam int CTRL_LOAD_BIT = 4;

  // ****************************************
  // Sizes and limits
  // ****************************************
  localparam int NUM_PAGES = 6;
  localparam int NUM_POS = 10;
  localparam int EXP_W = 12;
  localparam logic [3:0] POS_PW = 4'h9;
  localparam logic [3:0] POS_MAX = 4'h9;
  localparam logic [2:0] PAGE_MAX = 3'h5;
  localparam logic [EXP_W-1:0] MAX_DIRECT_HS = 12'h23C;
  localparam logic [EXP_W-1:0] MAX_DIRECT_LS = 12'h032;
  localparam logic [EXP_W-1:0] FULL_FRAME = 12'h001;

  // ****************************************
  // Factory default tables (positions 1..9)
  // ****************************************
  localparam logic [EXP_W-1:0] HS_DEF [NUM_POS] = '{
    12'h001, 12'h001, 12'h002, 12'h004, 12'h008,
    12'h011, 12'h023, 12'h048, 12'h090, 12'h12A};
  localparam logic [EXP_W-1:0] LS_DEF [NUM_POS] = '{
    12'h001, 12'h002, 12'h003, 12'h004, 12'h005,
    12'h006, 12'h007, 12'h008, 12'h009, 12'h00A};

  typedef enum logic [1:0] {
    SHEXP_IDLE = 2'b00,
    SHEXP_EXPO = 2'b01,
    SHEXP_PW = 2'b10
  } shexp_state_t;

endpackage : shexp_pkg

/* File: rtl/shexp_top.sv */
// Exposure-length selector with table memory behind a Wishbone slave
// What this block does
// - Position zero: ends at next frame pulse, a full frame when continuous
// - Nonzero position reads table unless direct value
// - Table entries editable except position zero
// - Separate table per page, active page used
// - High-speed defaults 1H to 298H
// - High-speed below one frame, both modes
// - Low-speed frame counts, continuous only, 2V-10V
// - Pulse width needs async, pos nine, enable
// - Enable off: position nine is fixed preset
// - Direct exposure as count of line periods
// - Six pages; power-on applies stored mode page
// - Common configuration shared by all pages
// - Mode switch set, read back and saved
// - Shutter switch is a memory value only
// - Pulse-width exposure lasts exactly trigger low time
// - Direct range check; zero cancels designation
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps

module shexp_top
  import shexp_pkg::*;
#(
  parameter int EXPW = shexp_pkg::EXP_W
) (
  input wire logic clk_i, // 40 MHz clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic wb_err_o, // Wishbone error, unmapped address
  input wire logic hsync_i, // Line period pulse
  input wire logic vsync_i, // Frame period pulse
  input wire logic trig_n_i, // External trigger, active low
  output logic expose_o, // Exposure window active
  output logic expose_done_o // One-cycle end of exposure
);
  import shexp_pkg::*;

  // ****************************************
  // State
  // ****************************************
  // All state except the page tables in one word, filled by one process
  typedef struct packed {
    logic [31:0] dat;
    logic ack;
    logic err;
    logic async_mode;
    logic low_speed;
    logic pwe;
    logic [3:0] sw_live;
    logic [3:0] sw_saved;
    logic [2:0] mode_live;
    logic [2:0] mode_saved;
    logic [2:0] page;
    logic [3:0] tbl_idx;
    logic [EXPW-1:0] direct;
    logic direct_bad;
    logic [EXPW-1:0] count;
    logic [EXPW-1:0] target;
    logic use_frames;
    shexp_state_t st;
    logic expose;
    logic done;
    logic trig_q;
    logic hs_q;
    logic vs_q;
    logic boot;
  } shexp_regs_t;

  shexp_regs_t r_q;
  shexp_regs_t r_d;

  // Per-page tables, one entry per position; entry zero unused
  logic [EXPW-1:0] hs_tbl_q [NUM_PAGES][NUM_POS];
  logic [EXPW-1:0] ls_tbl_q [NUM_PAGES][NUM_POS];

  logic acc;
  logic wr;
  logic [EXPW-1:0] max_direct;
  logic [EXPW-1:0] sel_len;
  logic sel_frames;
  logic pw_mode;
  logic hs_rise;
  logic vs_rise;
  logic tick;
  logic tbl_wr;
  logic trig_fall;
  logic [31:0] rd_word;

  // ****************************************
  // Bus decode and sync edges
  // ****************************************
  // Busy flags block a second take of one request
  assign acc = wb_cyc_i && wb_stb_i && !r_q.ack && !r_q.err;
  assign wr = acc && wb_we_i && wb_sel_i[0];
  assign hs_rise = hsync_i && !r_q.hs_q;
  assign vs_rise = vsync_i && !r_q.vs_q;
  assign trig_fall = !trig_n_i && r_q.trig_q;
  assign max_direct = r_q.low_speed ? MAX_DIRECT_LS : MAX_DIRECT_HS;
  assign tbl_wr = wr && wb_adr_i == ADR_TBL_DAT && r_q.tbl_idx != 4'h0;

  // ****************************************
  // Exposure selection
  // ****************************************
  always_comb begin
    pw_mode = r_q.async_mode && r_q.sw_live == POS_PW && r_q.pwe;
    sel_frames = 1'b1;
    sel_len = FULL_FRAME;
    if (r_q.sw_live == 4'h0) begin
      sel_frames = 1'b1;
      sel_len = FULL_FRAME;
    end else if (r_q.direct != '0 && !r_q.direct_bad) begin
      sel_frames = 1'b0;
      sel_len = r_q.direct;
    end else if (r_q.low_speed && !r_q.async_mode) begin
      sel_frames = 1'b1;
      sel_len = ls_tbl_q[r_q.page][r_q.sw_live];
    end else begin
      sel_frames = 1'b0;
      sel_len = hs_tbl_q[r_q.page][r_q.sw_live];
    end
    // Unit latched at start, not the live selection
    tick = r_q.use_frames ? vs_rise : hs_rise;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    r_d = r_q;
    r_d.ack = acc && !wb_err_o_d(wb_adr_i);
    r_d.err = acc && wb_err_o_d(wb_adr_i);
    r_d.done = 1'b0;
    r_d.trig_q = trig_n_i;
    r_d.hs_q = hsync_i;
    r_d.vs_q = vsync_i;
    r_d.boot = 1'b0;
    // Range flag follows speed changes
    r_d.direct_bad = r_q.direct > max_direct;

    // ****************************************
    // Boot and register writes
    // ****************************************
    // Reload repeats the power-on page pick
    if (r_q.boot) begin
      r_d.page = r_q.mode_saved;
      r_d.mode_live = r_q.mode_saved;
      r_d.sw_live = r_q.sw_saved;
    end
    if (wr) begin
      case (wb_adr_i)
        ADR_CTRL: begin
          r_d.async_mode = wb_dat_i[CTRL_ASYNC_BIT];
          r_d.low_speed = wb_dat_i[CTRL_LOWSPD_BIT];
          r_d.pwe = wb_dat_i[CTRL_PWE_BIT];
          if (wb_dat_i[CTRL_SAVE_BIT]) begin
            r_d.sw_saved = r_q.sw_live;
            r_d.mode_saved = r_q.mode_live;
          end
          if (wb_dat_i[CTRL_LOAD_BIT]) begin
            r_d.boot = 1'b1;
          end
        end
        ADR_SWITCH: begin
          if (wb_dat_i[3:0] <= POS_MAX) begin
            r_d.sw_live = wb_dat_i[3:0];
          end
        end
        ADR_MODE: begin
          if (wb_dat_i[2:0] <= PAGE_MAX) begin
            r_d.mode_live = wb_dat_i[2:0];
          end
        end
        ADR_DIRECT: begin
          r_d.direct = wb_dat_i[EXPW-1:0];
          r_d.direct_bad = wb_dat_i[EXPW-1:0] > max_direct;
        end
        ADR_TBL_IDX: begin
          if (wb_dat_i[3:0] <= POS_MAX) begin
            r_d.tbl_idx = wb_dat_i[3:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (acc && !wb_we_i) begin
      r_d.dat = rd_word;
    end

    // ****************************************
    // Exposure timer
    // ****************************************
    case (r_q.st)
      SHEXP_IDLE: begin
        // Starts are ignored outside idle
        if (pw_mode) begin
          if (trig_fall) begin
            r_d.st = SHEXP_PW;
            r_d.expose = 1'b1;
          end
        end else if (r_q.async_mode ? trig_fall : vs_rise) begin
          r_d.st = SHEXP_EXPO;
          r_d.expose = 1'b1;
          r_d.count = '0;
          r_d.target = sel_len;
          r_d.use_frames = sel_frames;
        end
      end
      SHEXP_EXPO: begin
        if (tick) begin
          r_d.count = EXPW'(r_q.count + 1'b1);
          if (EXPW'(r_q.count + 1'b1) >= r_q.target) begin
            r_d.st = SHEXP_IDLE;
            r_d.expose = 1'b0;
            r_d.done = 1'b1;
          end
        end
      end
      SHEXP_PW: begin
        // Trigger high again ends the window
        if (trig_n_i) begin
          r_d.st = SHEXP_IDLE;
          r_d.expose = 1'b0;
          r_d.done = 1'b1;
        end
      end
      default: begin
        r_d.st = SHEXP_IDLE;
        r_d.expose = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Readback
  // ****************************************
  // Active word shows the live selection, not the last latched target
  always_comb begin
    rd_word = 32'h0;
    case (wb_adr_i)
      ADR_CTRL: begin
        rd_word = {27'h0, 2'b00, r_q.pwe, r_q.low_speed, r_q.async_mode};
      end
      ADR_SWITCH: begin
        rd_word = {24'h0, r_q.sw_saved, r_q.sw_live};
      end
      ADR_MODE: begin
        rd_word = {25'h0, r_q.mode_saved, 1'b0, r_q.mode_live};
      end
      ADR_DIRECT: begin
        rd_word = {19'h0, r_q.direct_bad, r_q.direct};
      end
      ADR_TBL_IDX: begin
        rd_word = {28'h0, r_q.tbl_idx};
      end
      ADR_TBL_DAT: begin
        rd_word = {4'h0, 4'h0, ls_tbl_q[r_q.page][r_q.tbl_idx],
                   hs_tbl_q[r_q.page][r_q.tbl_idx]};
      end
      ADR_STATUS: begin
        rd_word = {26'h0, r_q.use_frames, pw_mode, r_q.st, r_q.expose,
                   r_q.direct_bad};
      end
      ADR_COUNT: begin
        rd_word = {20'h0, r_q.count};
      end
      ADR_ACTIVE: begin
        rd_word = {20'h0, sel_len};
      end
      default: begin
        rd_word = 32'h0;
      end
    endcase
  end

  // Unmapped address detection
  function automatic logic wb_err_o_d(input logic [7:0] a);
    wb_err_o_d = 1'b1;
    case (a)
      ADR_CTRL: wb_err_o_d = 1'b0;
      ADR_SWITCH: wb_err_o_d = 1'b0;
      ADR_MODE: wb_err_o_d = 1'b0;
      ADR_DIRECT: wb_err_o_d = 1'b0;
      ADR_TBL_IDX: wb_err_o_d = 1'b0;
      ADR_TBL_DAT: wb_err_o_d = 1'b0;
      ADR_STATUS: wb_err_o_d = 1'b0;
      ADR_COUNT: wb_err_o_d = 1'b0;
      ADR_ACTIVE: wb_err_o_d = 1'b0;
      default: wb_err_o_d = 1'b1;
    endcase
  endfunction : wb_err_o_d

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_q <= '0;
      r_q.boot <= 1'b1;
      r_q.trig_q <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ****************************************
  // Table memory
  // ****************************************
  // Defaults restored on reset; index zero never written, frame default holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < NUM_PAGES; p++) begin
        for (int i = 0; i < NUM_POS; i++) begin
          hs_tbl_q[p][i] <= HS_DEF[i];
          ls_tbl_q[p][i] <= LS_DEF[i];
        end
      end
    end else if (tbl_wr) begin
      hs_tbl_q[r_q.page][r_q.tbl_idx] <= wb_dat_i[EXPW-1:0];
      ls_tbl_q[r_q.page][r_q.tbl_idx] <= wb_dat_i[EXPW+15:16];
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_dat_o = r_q.dat;
  assign wb_ack_o = r_q.ack;
  assign wb_err_o = r_q.err;
  assign expose_o = r_q.expose;
  assign expose_done_o = r_q.done;

endmodule : shexp_top
